// File: common/fdc_defines.vh
// constants for the diskette controller host port: offsets, fields, opcodes
// assumes an 8-bit i/o bus with a 10-bit port address, one clock domain
// Function
// - write-only drive control register at 3f2
// - low bit alone selects drive 0 or 1
// - reset bit zero holds controller in reset
// - enable bit gates interrupt and dma requests
// - one bit switches first drive motor
// - another bit switches second drive motor
// - status register at 3f4 readable any time
// - data register at 3f5 carries all bytes
// - fifteen commands decoded from first byte opcode
// - opcode and parameters taken before execution
// - result bytes read back after execution
// - execution moves sector data drive and host
// - seven result bytes for data-moving commands: three status, then id
// - read track runs from index to final sector
// - read id returns first good id field
// - status byte zero top bits give termination
// - multi track flag continues from head 0 onto head 1
// - density select picks single or double density
// - skip flag passes deleted data sectors
`ifndef FDC_DEFINES_VH
`define FDC_DEFINES_VH
`define ADDR_DRIVE_CONTROL 10'h3f2
`define ADDR_CONTROLLER_STATUS 10'h3f4
`define ADDR_COMMAND_DATA_PORT 10'h3f5
`define DC_RESET 8'h00
`define DC_UNIT_LO 0
`define DC_UNIT_HI 1
`define DC_CTRL_RUN 2
`define DC_REQ_EN 3
`define DC_MOTOR_A 4
`define DC_MOTOR_B 5
`define MS_BUSY 4
`define MS_EXEC 5
`define MS_DIR_OUT 6
`define MS_READY 7
`define OP_READ_TRACK 5'h02
`define OP_SPECIFY 5'h03
`define OP_SENSE_DRIVE 5'h04
`define OP_WRITE_DATA 5'h05
`define OP_READ_DATA 5'h06
`define OP_RECAL 5'h07
`define OP_SENSE_INT 5'h08
`define OP_WRITE_DEL 5'h09
`define OP_READ_ID 5'h0a
`define OP_READ_DEL 5'h0c
`define OP_FORMAT 5'h0d
`define OP_SEEK 5'h0f
`define OP_SCAN_EQ 5'h11
`define OP_SCAN_LE 5'h19
`define OP_SCAN_HE 5'h1d
`define TERM_NORMAL 2'h0
`define TERM_ABNORMAL 2'h1
`define TERM_INVALID 2'h2
`define FIFO_DEPTH 16
`define DSK_TIMEOUT 16'hffff
`endif

// File: core/byte_fifo.v
// parameterised fifo for sector data between host port and drive side
// assumes synchronous reset and a single clock
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire i_clock,
    input wire i_sys_rst,
    // fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // drain side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
    reg [AW-1:0] wr_q; // write pointer
    reg [AW-1:0] rd_q; // read pointer
    reg [AW:0] cnt_q; // occupancy
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    assign o_in_ready = (cnt_q != DEPTH[AW:0]); // full stalls source
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}}); // empty
    assign o_out_data = mem[rd_q];
    // pointers and count
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
    // storage write
    always @(posedge i_clock) begin
        if (push) begin
            mem[wr_q] <= i_in_data;
        end
    end
endmodule // byte_fifo
`default_nettype wire

// File: core/fdc_host_port.v
// diskette controller host port: drive control, status, command data port
// assumes the host bus gives one-cycle read/write strobes with a port address
// and a drive-side byte stream with id and status inputs
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defines.vh"
module fdc_host_port #(
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter TIMEOUT = `DSK_TIMEOUT
) (
    // clock and reset
    input wire i_clock,
    input wire i_sys_rst,
    // host i/o bus
    input wire [9:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    // drive control outputs
    output reg [1:0] o_unit_select,
    output reg o_motor_a,
    output reg o_motor_b,
    output reg o_ctrl_reset,
    output reg o_irq,
    output reg o_dma_req,
    // drive-side data stream
    input wire i_dsk_valid,
    input wire [7:0] i_dsk_data,
    output reg o_dsk_ready,
    output reg o_dsk_wvalid,
    output reg [7:0] o_dsk_wdata,
    input wire i_dsk_wready,
    // drive-side sector flags
    input wire i_index,
    input wire i_deleted_mark,
    input wire i_id_ok,
    input wire i_crc_err,
    input wire i_drive_ready,
    // drive-side command qualifiers
    output reg o_density_select,
    output reg o_head_select
);
    // phase states, one-hot
    localparam S_CMD = 4'b0001;
    localparam S_EXEC = 4'b0010;
    localparam S_RES = 4'b0100;
    localparam S_IDLE = 4'b1000;

    reg [7:0] drive_control_q; // write-only register
    reg [3:0] state_q; // command phase
    reg [7:0] cmd_q [0:8]; // command bytes
    reg [7:0] res_q [0:6]; // result bytes
    reg [3:0] idx_q; // byte index in phase
    reg [3:0] need_q; // command length
    reg [3:0] nres_q; // result length
    reg [15:0] bytes_q; // bytes left in sector
    reg [15:0] tmo_q; // overrun watchdog
    reg [7:0] sector_q; // current sector
    reg head_q; // current head
    reg ready_at_start_q; // ready level at start
    reg [7:0] st1_q; // error flags
    reg in_track_q; // read track saw index
    reg drain_q; // all bytes queued, fifo emptying

    // command length for opcode
    function [3:0] cmd_len;
        input [4:0] op;
        begin
            case (op)
                `OP_READ_DATA, `OP_READ_DEL, `OP_WRITE_DATA, `OP_WRITE_DEL,
                `OP_READ_TRACK, `OP_SCAN_EQ, `OP_SCAN_LE,
                `OP_SCAN_HE: cmd_len = 4'd9;
                `OP_FORMAT: cmd_len = 4'd6;
                `OP_SPECIFY, `OP_SEEK: cmd_len = 4'd3;
                `OP_READ_ID, `OP_RECAL, `OP_SENSE_DRIVE: cmd_len = 4'd2;
                `OP_SENSE_INT: cmd_len = 4'd1;
                default: cmd_len = 4'd0;
            endcase
        end
    endfunction

    // data-moving commands
    function is_xfer;
        input [4:0] op;
        begin
            is_xfer = (cmd_len(op) == 4'd9) || (op == `OP_READ_ID);
        end
    endfunction

    wire [4:0] opcode = cmd_q[0][4:0];
    wire is_write = (opcode == `OP_WRITE_DATA) || (opcode == `OP_WRITE_DEL)
        || (opcode == `OP_FORMAT);
    wire run = drive_control_q[`DC_CTRL_RUN];
    wire sel_data = (i_addr == `ADDR_COMMAND_DATA_PORT);
    wire host_wr_data = i_wr && sel_data && run;
    wire host_rd_data = i_rd && sel_data && run;

    // fifo wiring
    wire f_in_valid;
    wire [7:0] f_in_data;
    wire f_in_ready;
    wire f_out_valid;
    wire [7:0] f_out_data;
    wire f_out_ready;
    wire exec_rd = (state_q == S_EXEC) && !is_write;
    wire exec_wr = (state_q == S_EXEC) && is_write;
    // skip deleted sectors when flagged
    wire skip_now = cmd_q[0][5] && i_deleted_mark && !is_write;
    // read track starts only after index
    wire track_gate = (opcode != `OP_READ_TRACK) || in_track_q || i_index;
    wire dsk_take = i_dsk_valid && o_dsk_ready; // drive byte handed over
    assign f_in_valid = !drain_q && (exec_rd ? (dsk_take && !skip_now
        && track_gate && (opcode != `OP_READ_ID || i_id_ok))
        : (exec_wr && host_wr_data));
    assign f_in_data = exec_rd ? i_dsk_data : i_wdata;
    assign f_out_ready = exec_rd ? host_rd_data
        : (i_dsk_wready || !o_dsk_wvalid);

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(4)) u_fifo (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst || !run),
        .i_in_valid(f_in_valid),
        .i_in_data(f_in_data),
        .o_in_ready(f_in_ready),
        .o_out_valid(f_out_valid),
        .o_out_data(f_out_data),
        .i_out_ready(f_out_ready)
    );

    // main status byte composed from phase
    wire [7:0] main_status = {
        (state_q == S_CMD || state_q == S_IDLE || state_q == S_RES)
            || (exec_rd ? f_out_valid : (f_in_ready && !drain_q)),
        (state_q == S_RES) || exec_rd,
        (state_q == S_EXEC),
        (state_q != S_CMD) || (idx_q != 4'h0), // busy once a byte is in
        2'h0,
        o_unit_select};

    // drive control register writes
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            drive_control_q <= `DC_RESET;
        end else if (i_wr && i_addr == `ADDR_DRIVE_CONTROL) begin
            drive_control_q <= i_wdata;
        end
    end

    // registered control outputs
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_unit_select <= 2'h0;
            o_motor_a <= 1'b0;
            o_motor_b <= 1'b0;
            o_ctrl_reset <= 1'b1;
            o_irq <= 1'b0;
            o_dma_req <= 1'b0;
            o_density_select <= 1'b0;
            o_head_select <= 1'b0;
        end else begin
            // select only drive 0 or 1
            o_unit_select <= {1'b0, drive_control_q[`DC_UNIT_LO]};
            o_motor_a <= drive_control_q[`DC_MOTOR_A];
            o_motor_b <= drive_control_q[`DC_MOTOR_B];
            o_ctrl_reset <= !run;
            // requests gated by enable bit
            o_irq <= drive_control_q[`DC_REQ_EN] && (state_q == S_RES);
            o_dma_req <= drive_control_q[`DC_REQ_EN] && (state_q == S_EXEC)
                && (exec_rd ? f_out_valid : f_in_ready);
            o_density_select <= cmd_q[0][6];
            o_head_select <= head_q;
        end
    end

    // host read data mux; drive control reads as zero
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            if (i_addr == `ADDR_CONTROLLER_STATUS) begin
                o_rdata <= main_status;
            end else if (sel_data && state_q == S_RES) begin
                o_rdata <= res_q[idx_q[2:0]];
            end else if (sel_data && exec_rd) begin
                o_rdata <= f_out_data;
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end

    // drive-side read ready and write stream
    always @(posedge i_clock) begin
        if (i_sys_rst || !run) begin
            o_dsk_wvalid <= 1'b0;
            o_dsk_wdata <= 8'h00;
            o_dsk_ready <= 1'b0;
        end else begin
            o_dsk_ready <= exec_rd && is_xfer(opcode) && !drain_q
                && f_in_ready && !dsk_take; // drops after each take
            if (f_out_ready && !exec_rd) begin
                o_dsk_wvalid <= f_out_valid && exec_wr;
                o_dsk_wdata <= f_out_data;
            end
        end
    end

    // command phase sequencer
    always @(posedge i_clock) begin
        if (i_sys_rst || !run) begin
            state_q <= S_CMD;
            idx_q <= 4'h0;
            need_q <= 4'h0;
            nres_q <= 4'h0;
            bytes_q <= 16'h0000;
            tmo_q <= 16'h0000;
            sector_q <= 8'h00;
            head_q <= 1'b0;
            ready_at_start_q <= 1'b0;
            st1_q <= 8'h00;
            in_track_q <= 1'b0;
            drain_q <= 1'b0;
        end else begin
            case (state_q)
                S_CMD: begin
                    if (host_wr_data) begin
                        cmd_q[idx_q] <= i_wdata;
                        if (idx_q == 4'h0) begin
                            need_q <= cmd_len(i_wdata[4:0]);
                        end
                        if (idx_q == 4'h0 && cmd_len(i_wdata[4:0]) == 4'd0)
                        begin
                            // invalid opcode answers one byte
                            res_q[0] <= {`TERM_INVALID, 6'h00};
                            nres_q <= 4'd1;
                            idx_q <= 4'h0;
                            state_q <= S_RES;
                        end else if (idx_q + 4'h1 ==
                            (idx_q == 4'h0 ? cmd_len(i_wdata[4:0]) : need_q))
                        begin
                            idx_q <= 4'h0;
                            state_q <= S_EXEC;
                            ready_at_start_q <= i_drive_ready;
                            sector_q <= cmd_q[4];
                            head_q <= (idx_q == 4'h1) ? i_wdata[2] // on bus
                                : cmd_q[1][2];
                            bytes_q <= {8'h00, i_wdata}; // data length
                            tmo_q <= TIMEOUT[15:0];
                            st1_q <= 8'h00;
                            in_track_q <= 1'b0;
                            drain_q <= 1'b0;
                        end else begin
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                S_EXEC: begin
                    if (i_index) begin
                        in_track_q <= 1'b1;
                    end
                    if (i_crc_err) begin
                        st1_q[5] <= 1'b1; // data error
                    end
                    tmo_q <= tmo_q - 16'h1;
                    if (!is_xfer(opcode)) begin
                        state_q <= S_RES; // seek-class finishes at once
                        res_q[0] <= {`TERM_NORMAL, 3'h0, head_q,
                            o_unit_select}; // fresh byte
                    end else if (drain_q) begin
                        tmo_q <= TIMEOUT[15:0];
                        if (!f_out_valid && !o_dsk_wvalid) begin
                            state_q <= S_RES; // all bytes gone
                        end
                    end else if (f_in_valid && f_in_ready) begin
                        tmo_q <= TIMEOUT[15:0];
                        if (opcode == `OP_READ_ID || bytes_q == 16'h1) begin
                            if (sector_q == cmd_q[6]) begin
                                if (cmd_q[0][7] && !head_q) begin
                                    head_q <= 1'b1;
                                    sector_q <= 8'h01;
                                    bytes_q <= {8'h00, cmd_q[8]};
                                end else begin
                                    drain_q <= 1'b1;
                                end
                            end else begin
                                sector_q <= sector_q + 8'h01;
                                bytes_q <= {8'h00, cmd_q[8]};
                            end
                            if (opcode == `OP_READ_ID) begin
                                drain_q <= 1'b1;
                            end
                        end else begin
                            bytes_q <= bytes_q - 16'h1;
                        end
                    end else if (tmo_q == 16'h0) begin
                        st1_q[4] <= 1'b1; // overrun
                        state_q <= S_RES;
                    end
                    if (state_q == S_EXEC && is_xfer(opcode)) begin
                        nres_q <= 4'd7;
                    end else begin
                        nres_q <= 4'd1;
                    end
                end
                S_RES: begin
                    // result bytes in fixed order
                    if (idx_q == 4'h0 && nres_q != 4'd1) begin
                        res_q[0] <= {(ready_at_start_q != i_drive_ready)
                            ? 2'h3 : ((st1_q != 8'h00) ? `TERM_ABNORMAL
                            : `TERM_NORMAL), 3'h0, head_q,
                            cmd_q[1][1:0]};
                        res_q[1] <= st1_q;
                        res_q[2] <= 8'h00;
                        res_q[3] <= cmd_q[2];
                        res_q[4] <= {7'h00, head_q};
                        res_q[5] <= sector_q;
                        res_q[6] <= cmd_q[5];
                    end
                    if (host_rd_data) begin
                        if (idx_q + 4'h1 >= nres_q) begin
                            idx_q <= 4'h0;
                            state_q <= S_CMD;
                        end else begin
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= S_CMD;
                end
            endcase
        end
    end
endmodule // fdc_host_port
`default_nettype wire

// File: bench/fdc_host_port_asserts.sv
// checker on the diskette host port pins, bound into its top module
// assumes one clock, sync active-high reset, defines header on the path
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defines.vh"
module fdc_host_port_asserts (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // host bus
    input wire logic [9:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    // drive control
    input wire logic [1:0] o_unit_select,
    input wire logic o_motor_a,
    input wire logic o_motor_b,
    input wire logic o_ctrl_reset,
    input wire logic o_irq,
    input wire logic o_dma_req,
    // write stream toward the drive
    input wire logic o_dsk_wvalid,
    input wire logic [7:0] o_dsk_wdata,
    input wire logic i_dsk_wready
);
    wire ctl_wr = i_wr && (i_addr == `ADDR_DRIVE_CONTROL); // control write
    reg [7:0] ctl_q; // last drive control value
    // shadow of the drive control register
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            ctl_q <= 8'h00;
        end else if (ctl_wr) begin
            ctl_q <= i_wdata;
        end
    end
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // a control write and the edge after it
    sequence s_ctl_write;
        ctl_wr ##1 1'b1;
    endsequence
    a_unit_follows: assert property (
        s_ctl_write |-> ##[0:1] o_unit_select == {1'b0, ctl_q[0]})
        else $error("unit select off");
    a_reset_held: assert property (
        s_ctl_write |-> ##[0:1] o_ctrl_reset == !ctl_q[2])
        else $error("controller reset off");
    a_motor_a_follows: assert property (
        s_ctl_write |-> ##[0:1] o_motor_a == ctl_q[4])
        else $error("first motor off");
    a_motor_b_follows: assert property (
        s_ctl_write |-> ##[0:1] o_motor_b == ctl_q[5])
        else $error("second motor off");
    a_req_gated: assert property (
        !(ctl_q[3] || $past(ctl_q[3]) || $past(ctl_q[3], 2))
        |-> !o_irq && !o_dma_req)
        else $error("request while disabled");
    a_held_quiet: assert property (
        o_ctrl_reset && $past(o_ctrl_reset)
        |-> !o_dsk_wvalid && !o_irq && !o_dma_req)
        else $error("activity while held");
    a_ctl_read_zero: assert property (
        i_rd && i_addr == `ADDR_DRIVE_CONTROL |=> (o_rdata == 8'h00) [*2])
        else $error("drive control read not zero");
    a_wdata_hold: assert property (
        o_dsk_wvalid && !i_dsk_wready
        |=> o_dsk_wvalid && $stable(o_dsk_wdata))
        else $error("write byte dropped or changed");
endmodule // fdc_host_port_asserts
bind fdc_host_port fdc_host_port_asserts chk (.i_clock, .i_sys_rst,
    .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .o_unit_select, .o_motor_a,
    .o_motor_b, .o_ctrl_reset, .o_irq, .o_dma_req, .o_dsk_wvalid,
    .o_dsk_wdata, .i_dsk_wready);
`default_nettype wire

// File: bench/disk_model.sv
// drive-side model: byte source for reads, byte sink for writes, flags
// assumes valid/ready streams sampled on the rising edge, one clock
`timescale 1ns/1ps
`default_nettype none
module disk_model (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // read stream
    output logic o_valid,
    output logic [7:0] o_data,
    input wire logic i_ready,
    // write stream
    input wire logic i_wvalid,
    input wire logic [7:0] i_wdata,
    output logic o_wready,
    // sector flags
    output logic o_index,
    output logic o_deleted,
    output logic o_id_ok,
    output logic o_crc_err,
    output logic o_drv_ready
);
    logic [7:0] tick_q; // free-running cycle count
    logic [7:0] rd_q; // bytes handed out
    logic [3:0] wr_q; // bytes taken in
    logic [7:0] got [0:15]; // bytes written to the medium
    wire [7:0] pat = 8'ha0 + rd_q; // next sector byte
    // stalls one cycle in four; inverse data while idle
    assign o_valid = tick_q[1:0] != 2'h3;
    assign o_data = o_valid ? pat : ~pat;
    assign o_wready = tick_q[0]; // slow sink
    assign o_index = tick_q == 8'h00; // index hole
    assign o_deleted = 1'b0; // no deleted marks
    assign o_id_ok = 1'b1; // id fields read clean
    assign o_crc_err = 1'b0; // no crc faults
    assign o_drv_ready = 1'b1; // ready never changes
    // counters and write capture
    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            tick_q <= 8'h00;
            rd_q <= 8'h00;
            wr_q <= 4'h0;
        end else begin
            tick_q <= tick_q + 8'h01;
            if (o_valid && i_ready) begin
                rd_q <= rd_q + 8'h01;
            end
            if (i_wvalid && o_wready) begin
                got[wr_q] <= i_wdata;
                wr_q <= wr_q + 4'h1;
            end
        end
    end
endmodule // disk_model
`default_nettype wire

// File: bench/fdc_host_port_tb.sv
// self-checking bench for the diskette host port
// assumes the defines header on the path and the drive model beside it
`timescale 1ns/1ps
`default_nettype none
`include "fdc_defines.vh"
module fdc_host_port_tb;
    logic i_clock = 1'b0; // 250 MHz
    logic i_sys_rst = 1'b1; // held four cycles
    logic [9:0] i_addr = 10'h000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    wire [7:0] o_rdata, o_dsk_wdata, i_dsk_data;
    wire [1:0] o_unit_select;
    wire o_motor_a, o_motor_b, o_ctrl_reset, o_irq, o_dma_req;
    wire o_dsk_ready, o_dsk_wvalid, o_density_select, o_head_select;
    wire i_dsk_valid, i_dsk_wready, i_index, i_deleted_mark;
    wire i_id_ok, i_crc_err, i_drive_ready;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] d, s, r0; // read bytes
    logic [7:0] ctl [0:4] = '{8'h00, 8'h11, 8'h2d, 8'h15, 8'h34};
    logic [4:0] ops [0:14] = '{`OP_READ_TRACK, `OP_SPECIFY,
        `OP_SENSE_DRIVE, `OP_WRITE_DATA, `OP_READ_DATA, `OP_RECAL,
        `OP_SENSE_INT, `OP_WRITE_DEL, `OP_READ_ID, `OP_READ_DEL, `OP_FORMAT,
        `OP_SEEK, `OP_SCAN_EQ, `OP_SCAN_LE, `OP_SCAN_HE};
    logic [7:0] rdc [0:8] = '{8'h46, 8'h04, 8'h02, 8'h01, 8'h03, 8'h00,
        8'h03, 8'h1b, 8'h04}; // read, double density, head one
    logic [7:0] wrc [0:8] = '{8'h05, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00,
        8'h01, 8'h1b, 8'h04}; // write, single density, head zero
    fdc_host_port #(.TIMEOUT(16)) uut (.i_clock, .i_sys_rst, .i_addr,
        .i_wr, .i_rd, .i_wdata, .o_rdata, .o_unit_select, .o_motor_a,
        .o_motor_b, .o_ctrl_reset, .o_irq, .o_dma_req, .i_dsk_valid,
        .i_dsk_data, .o_dsk_ready, .o_dsk_wvalid, .o_dsk_wdata,
        .i_dsk_wready, .i_index, .i_deleted_mark, .i_id_ok, .i_crc_err,
        .i_drive_ready, .o_density_select, .o_head_select);
    disk_model dm (.i_clock, .i_sys_rst, .o_valid(i_dsk_valid),
        .o_data(i_dsk_data), .i_ready(o_dsk_ready), .i_wvalid(o_dsk_wvalid),
        .i_wdata(o_dsk_wdata), .o_wready(i_dsk_wready), .o_index(i_index),
        .o_deleted(i_deleted_mark), .o_id_ok(i_id_ok),
        .o_crc_err(i_crc_err), .o_drv_ready(i_drive_ready));
    // clock generator
    initial begin
        forever #2 i_clock = ~i_clock;
    end
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks = n_checks + 1;
        if (seen !== want) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one-cycle write strobe
    task automatic bus_wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    // one-cycle read strobe, data taken once registered
    task automatic bus_rd(input logic [9:0] a, output logic [7:0] v);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(posedge i_clock);
        #1 v = o_rdata;
    endtask
    // poll status until ready with the wanted direction
    task automatic wait_dir(input logic dir);
        logic [7:0] st;
        int k;
        for (k = 0; k < 500; k++) begin
            bus_rd(`ADDR_CONTROLLER_STATUS, st);
            if (st[`MS_READY] === 1'b1 && st[`MS_DIR_OUT] === dir) break;
        end
        if (k == 500) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: status wait expired", $time);
            close_out();
        end
    endtask
    // polled byte to and from the data port
    task automatic put(input logic [7:0] v);
        wait_dir(1'b0);
        bus_wr(`ADDR_COMMAND_DATA_PORT, v);
    endtask
    task automatic get(output logic [7:0] v);
        wait_dir(1'b1);
        bus_rd(`ADDR_COMMAND_DATA_PORT, v);
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        #1 check({7'h00, o_ctrl_reset}, 8'h01);
        bus_wr(`ADDR_COMMAND_DATA_PORT, 8'h06); // must be ignored
        for (int i = 0; i < 5; i++) begin
            bus_wr(`ADDR_DRIVE_CONTROL, ctl[i]);
            repeat (2) @(posedge i_clock);
            #1 check({2'h0, o_motor_b, o_motor_a, 1'b0, o_ctrl_reset,
                o_unit_select}, {2'h0, ctl[i][5:4], 1'b0, ~ctl[i][2],
                1'b0, ctl[i][0]});
        end
        bus_rd(`ADDR_DRIVE_CONTROL, d);
        check(d, 8'h00);
        bus_rd(`ADDR_CONTROLLER_STATUS, s);
        check(s & 8'hd0, 8'h80);
        put(8'h00);
        get(d);
        check(d, 8'h80);
        bus_rd(`ADDR_CONTROLLER_STATUS, s);
        check(s & 8'hd0, 8'h80);
        for (int i = 0; i < 15; i++) begin
            put({3'h0, ops[i]});
            wait_dir(ops[i] == `OP_SENSE_INT);
            bus_rd(`ADDR_CONTROLLER_STATUS, s);
            check({7'h00, s[`MS_BUSY]}, 8'h01);
            bus_wr(`ADDR_DRIVE_CONTROL, 8'h30);
            bus_wr(`ADDR_DRIVE_CONTROL, 8'h34);
        end
        for (int i = 0; i < 9; i++) put(rdc[i]);
        repeat (2) @(posedge i_clock);
        #1 check({6'h0, o_density_select, o_head_select}, 8'h03);
        for (int i = 0; i < 4; i++) begin
            get(d);
            check(d, 8'ha0 + i[7:0]);
        end
        get(r0);
        check(r0 & 8'hc7, 8'h04);
        repeat (6) get(d);
        bus_rd(`ADDR_CONTROLLER_STATUS, s);
        check(s & 8'hd0, 8'h80);
        bus_wr(`ADDR_DRIVE_CONTROL, 8'h3c);
        for (int i = 0; i < 9; i++) put(wrc[i]);
        for (int i = 0; i < 4; i++) put(8'h5a + i[7:0]);
        get(r0);
        check(r0 & 8'hc7, 8'h00);
        check({7'h00, o_irq}, 8'h01);
        repeat (6) get(d);
        for (int i = 0; i < 4; i++) check(dm.got[i], 8'h5a + i[7:0]);
        check({7'h00, o_density_select}, 8'h00);
        check({6'h00, o_irq, o_dma_req}, 8'h00);
        close_out();
    end
endmodule // fdc_host_port_tb
`default_nettype wire
